// ### inc/pmrx_map.svh
// Constants for the MII/RMII receive port: widths, strap codes, clock timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PMRX_MAP_SVH
`define PMRX_MAP_SVH

// FIFO word: {error, data[3:0]}
`define PMRX_DW          5
`define PMRX_DEPTH       16
`define PMRX_AW          4
`define PMRX_ERR_BIT     4

// Media mode codes, {valid strap, data bit 3 strap}
`define PMRX_MODE_MII    2'h0
`define PMRX_MODE_RMII_B 2'h1
`define PMRX_MODE_RCLKO  2'h2
`define PMRX_MODE_RCLKI  2'h3

// Clock timing
`define PMRX_CLK_NS      5
`define PMRX_REF_MHZ     50
`define PMRX_REF_HALF    (1000 / (2 * `PMRX_REF_MHZ * `PMRX_CLK_NS))
`define PMRX_REF_CW      2

`endif

// ### inc/pmrx_pkg.sv
// Types and shared functions of the MII/RMII receive port.
// Assumes pmrx_map.svh is on the include path.
`include "pmrx_map.svh"

package pmrx_pkg;

    // Media mode selected by the straps
    typedef enum logic [1:0] {
        PMRX_MII     = `PMRX_MODE_MII,
        PMRX_REV_MII = `PMRX_MODE_RMII_B,
        PMRX_RMII_CO = `PMRX_MODE_RCLKO,
        PMRX_RMII_CI = `PMRX_MODE_RCLKI
    } pmrx_mode_t;

    // Link-side output sequencer
    typedef enum logic [3:0] {
        PMRX_ST_IDLE = 4'h1,
        PMRX_ST_NIB  = 4'h2,
        PMRX_ST_LO   = 4'h4,
        PMRX_ST_HI   = 4'h8
    } pmrx_lstate_t;

    // Binary to gray for FIFO pointers
    function automatic logic [`PMRX_AW:0] pmrx_bin2gray(input logic [`PMRX_AW:0] b);
        pmrx_bin2gray = b ^ (b >> 1);
    endfunction

endpackage

// ### inc/pmrx_fifo_if.sv
// Valid/ready carrier between the receive port and its FIFO.
// Assumes the writer runs on the system clock and the reader on the link clock.
`timescale 1ns/1ps
`include "pmrx_map.svh"

interface pmrx_fifo_if;
    logic                 wr_valid;
    logic                 wr_ready;
    logic [`PMRX_DW-1:0]  wr_data;
    logic                 rd_valid;
    logic                 rd_ready;
    logic [`PMRX_DW-1:0]  rd_data;

    modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
    modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface

// ### core/pmrx_fifo.sv
// Dual-clock FIFO with gray-coded pointers and valid/ready on both sides.
// Assumes each side's reset is synchronous to its own clock.
`timescale 1ns/1ps
`include "pmrx_map.svh"

module pmrx_fifo #(
    parameter int DW = `PMRX_DW,
    parameter int AW = `PMRX_AW
) (
    input  wire logic  wclk_i,
    input  wire logic  wrst_n_i,
    input  wire logic  rclk_i,
    input  wire logic  rrst_n_i,
    pmrx_fifo_if.fifo  port
);
    import pmrx_pkg::*;

    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [AW:0]   wbin_ff, wgray_ff, rbin_ff, rgray_ff;
    logic [AW:0]   rg_s1_ff, rg_s2_ff, wg_s1_ff, wg_s2_ff;
    logic          wrdy_ff, empty_ff;
    logic [AW:0]   nxt_wbin, nxt_wgray, nxt_rbin, nxt_rgray;
    logic          push, pop;

    assign push          = port.wr_valid & wrdy_ff;
    assign pop           = port.rd_ready & ~empty_ff;
    assign nxt_wbin      = wbin_ff + {{AW{1'b0}}, push};
    assign nxt_rbin      = rbin_ff + {{AW{1'b0}}, pop};
    assign nxt_wgray     = pmrx_bin2gray(nxt_wbin);
    assign nxt_rgray     = pmrx_bin2gray(nxt_rbin);
    assign port.wr_ready = wrdy_ff;
    assign port.rd_valid = ~empty_ff;
    assign port.rd_data  = mem[rbin_ff[AW-1:0]];

    // Write side: storage, pointer, full flag
    always_ff @(posedge wclk_i) begin
        if (push) begin
            mem[wbin_ff[AW-1:0]] <= port.wr_data;
        end
    end

    always_ff @(posedge wclk_i) begin
        if (!wrst_n_i) begin
            wbin_ff  <= '0;
            wgray_ff <= '0;
            wrdy_ff  <= 1'b0;
        end else begin
            wbin_ff  <= nxt_wbin;
            wgray_ff <= nxt_wgray;
            wrdy_ff  <= (nxt_wgray != {~rg_s2_ff[AW:AW-1], rg_s2_ff[AW-2:0]});
        end
    end

    // Read pointer into the write domain
    always_ff @(posedge wclk_i) begin
        rg_s1_ff <= rgray_ff;
        rg_s2_ff <= rg_s1_ff;
    end

    // Read side: pointer, empty flag
    always_ff @(posedge rclk_i) begin
        if (!rrst_n_i) begin
            rbin_ff  <= '0;
            rgray_ff <= '0;
            empty_ff <= 1'b1;
        end else begin
            rbin_ff  <= nxt_rbin;
            rgray_ff <= nxt_rgray;
            empty_ff <= (nxt_rgray == wg_s2_ff);
        end
    end

    // Write pointer into the read domain
    always_ff @(posedge rclk_i) begin
        wg_s1_ff <= wgray_ff;
        wg_s2_ff <= wg_s1_ff;
    end

endmodule // pmrx_fifo

// ### core/pmrx_rx_port.sv
// Receive side of the PHY's MAC-facing port in MII or RMII form.
// Assumes decoded symbols arrive on the system clock; pins face the link clock.
`timescale 1ns/1ps
`include "pmrx_map.svh"

module pmrx_rx_port (
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  rx_clk_i,
    input  wire logic                  sym_valid_i,
    input  wire logic [3:0]            sym_data_i,
    input  wire logic                  sym_err_i,
    output logic                       sym_ready_o,
    input  wire logic                  carrier_i,
    input  wire logic                  irq_req_i,
    input  wire logic                  strap_dv_i,
    input  wire logic                  strap_d3_i,
    output logic                       rx_dv_o,
    output logic                       rx_dv_oe_o,
    output logic [3:0]                 rx_d_o,
    output logic [3:0]                 rx_d_oe_o,
    output logic                       rx_er_o,
    output logic                       crs_dv_o,
    output logic                       ref_clk_o,
    output logic                       ref_clk_oe_o,
    output pmrx_pkg::pmrx_mode_t       media_mode_o
);
    import pmrx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////////

    pmrx_fifo_if u_fifo_if ();

    // System domain
    logic                      strap_dv_s1_ff;
    logic                      strap_dv_s2_ff;
    logic                      strap_d3_s1_ff;
    logic                      strap_d3_s2_ff;
    pmrx_mode_t                mode_ff;
    logic [`PMRX_REF_CW-1:0]   ref_cnt_ff;
    logic                      ref_clk_ff;
    logic                      ref_oe_ff;
    logic                      rmii_clock_out_mode;
    logic                      rmii_clock_in_mode;

    // Link domain
    logic                      lrst_s1_ff;
    logic                      lrst_s2_ff;
    logic [1:0]                lmode_s1_ff;
    logic [1:0]                lmode_s2_ff;
    logic                      crs_s1_ff;
    logic                      crs_s2_ff;
    logic                      irq_s1_ff;
    logic                      irq_s2_ff;
    pmrx_lstate_t              lst_ff;
    pmrx_lstate_t              nxt_lst;
    logic [1:0]                hi_dibit_ff;
    logic                      hi_err_ff;
    logic                      dv_ff;
    logic [3:0]                d_ff;
    logic [3:0]                d_oe_ff;
    logic                      dv_oe_ff;
    logic                      er_ff;
    logic                      crs_dv_ff;
    logic                      rmii_lk;
    logic                      irq_out_n;
    logic                      take;
    logic [3:0]                w_data;
    logic                      w_err;

    ////////////////////////////////////////////////////////////////////////////
    // System domain: straps and mode
    ////////////////////////////////////////////////////////////////////////////

    // Pin synchronisers for the strap pins; no reset so reset-time levels pass
    // The strap pins are the valid pin and data bit 3, released during reset
    always_ff @(posedge clk_i) begin
        strap_dv_s1_ff <= strap_dv_i;
        strap_dv_s2_ff <= strap_dv_s1_ff;
        strap_d3_s1_ff <= strap_d3_i;
        strap_d3_s2_ff <= strap_d3_s1_ff;
    end

    // Mode follows straps while reset is held, frozen after release.
    // The level seen at the last reset edge wins, so straps that move
    // after release cannot change the media mode.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            mode_ff <= pmrx_mode_t'({strap_dv_s2_ff, strap_d3_s2_ff});
        end
    end

    assign rmii_clock_out_mode = (mode_ff == PMRX_RMII_CO);
    assign rmii_clock_in_mode  = (mode_ff == PMRX_RMII_CI);

    ////////////////////////////////////////////////////////////////////////////
    // System domain: reference clock output
    ////////////////////////////////////////////////////////////////////////////

    // Divider from the system clock to the 50 MHz reference.
    // Toggling every second edge divides by four; it runs in every mode and
    // only the pin enable decides whether the MAC sees it.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ref_cnt_ff <= '0;
            ref_clk_ff <= 1'b0;
        end else if (ref_cnt_ff == `PMRX_REF_CW'(`PMRX_REF_HALF - 1)) begin
            ref_cnt_ff <= '0;
            ref_clk_ff <= ~ref_clk_ff;
        end else begin
            ref_cnt_ff <= ref_cnt_ff + `PMRX_REF_CW'(1);
        end
    end

    // Drive the clock pin only in clock-out mode; in clock-in mode the MAC drives it
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ref_oe_ff <= 1'b0;
        end else begin
            ref_oe_ff <= rmii_clock_out_mode & ~rmii_clock_in_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System domain: symbol intake into the FIFO
    ////////////////////////////////////////////////////////////////////////////

    // Offer symbols to the FIFO. Ready is the FIFO's own registered not-full,
    // low in reset, which already counts the push made in the same cycle.
    // A local copy of it would lag by one edge and tell the source that a
    // word was taken while the FIFO was full, so that word would be lost.
    // Symbols offered while ready is low are simply held by the source.
    assign u_fifo_if.wr_valid = sym_valid_i & u_fifo_if.wr_ready;
    assign u_fifo_if.wr_data  = {sym_err_i, sym_data_i};

    pmrx_fifo #(
        .DW (`PMRX_DW),
        .AW (`PMRX_AW)
    ) u_fifo (
        .wclk_i   (clk_i),
        .wrst_n_i (reset_n_i),
        .rclk_i   (rx_clk_i),
        .rrst_n_i (lrst_s2_ff),
        .port     (u_fifo_if.fifo)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: crossings
    ////////////////////////////////////////////////////////////////////////////

    // Reset into the link domain; release arrives two link edges late and
    // the FIFO's read half stays cleared until then
    always_ff @(posedge rx_clk_i) begin
        lrst_s1_ff <= reset_n_i;
        lrst_s2_ff <= lrst_s1_ff;
    end

    // Static mode, carrier and interrupt request levels into the link domain.
    // The mode settles while reset is held, so plain samples are safe; the
    // levels are slow and a pulse shorter than a link cycle may be missed.
    always_ff @(posedge rx_clk_i) begin
        lmode_s1_ff <= mode_ff;
        lmode_s2_ff <= lmode_s1_ff;
        crs_s1_ff   <= carrier_i;
        crs_s2_ff   <= crs_s1_ff;
        irq_s1_ff   <= irq_req_i;
        irq_s2_ff   <= irq_s1_ff;
    end

    assign rmii_lk   = lmode_s2_ff[1];
    assign irq_out_n = ~irq_s2_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: output sequencer
    ////////////////////////////////////////////////////////////////////////////

    // MII takes a word each cycle; RMII takes one every second cycle.
    // Reads stall in the low-dibit cycle so the high dibit always follows
    // its own low dibit, even when the FIFO refills in between.
    assign u_fifo_if.rd_ready = lrst_s2_ff & (~rmii_lk | (lst_ff != PMRX_ST_LO));
    assign take               = u_fifo_if.rd_ready & u_fifo_if.rd_valid;
    assign w_data             = u_fifo_if.rd_data[3:0];
    assign w_err              = u_fifo_if.rd_data[`PMRX_ERR_BIT];

    // Next state; any state but the low-dibit one may take a new word
    always_comb begin
        nxt_lst = lst_ff;
        unique case (lst_ff)
            PMRX_ST_IDLE,
            PMRX_ST_NIB,
            PMRX_ST_HI: begin
                if (!take) begin
                    nxt_lst = PMRX_ST_IDLE;
                end else if (rmii_lk) begin
                    nxt_lst = PMRX_ST_LO;
                end else begin
                    nxt_lst = PMRX_ST_NIB;
                end
            end
            PMRX_ST_LO: begin
                nxt_lst = PMRX_ST_HI;
            end
            default: begin
                nxt_lst = PMRX_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge rx_clk_i) begin
        if (!lrst_s2_ff) begin
            lst_ff <= PMRX_ST_IDLE;
        end else begin
            lst_ff <= nxt_lst;
        end
    end

    // Upper dibit and error held for the second RMII cycle
    always_ff @(posedge rx_clk_i) begin
        if (!lrst_s2_ff) begin
            hi_dibit_ff <= 2'h0;
            hi_err_ff   <= 1'b0;
        end else if (take) begin
            hi_dibit_ff <= w_data[3:2];
            hi_err_ff   <= w_err;
        end
    end

    // Valid and data; MII data forced to zero whenever valid is low.
    // The separate valid pin stays low in RMII; the combined output carries it.
    always_ff @(posedge rx_clk_i) begin
        if (!lrst_s2_ff) begin
            dv_ff <= 1'b0;
            d_ff  <= 4'h0;
        end else if (lst_ff == PMRX_ST_LO) begin
            dv_ff <= 1'b0;
            d_ff  <= {2'h0, hi_dibit_ff};
        end else if (take && rmii_lk) begin
            dv_ff <= 1'b0;
            d_ff  <= {2'h0, w_data[1:0]};
        end else if (take) begin
            dv_ff <= 1'b1;
            d_ff  <= w_data;
        end else begin
            dv_ff <= 1'b0;
            d_ff  <= 4'h0;
        end
    end

    // Error on the rising link edge alongside the symbol that carried it;
    // in RMII it repeats on both dibits of its nibble
    always_ff @(posedge rx_clk_i) begin
        if (!lrst_s2_ff) begin
            er_ff <= 1'b0;
        end else if (lst_ff == PMRX_ST_LO) begin
            er_ff <= hi_err_ff;
        end else begin
            er_ff <= take & w_err;
        end
    end

    // Carrier sense in MII; combined carrier and valid in RMII
    always_ff @(posedge rx_clk_i) begin
        if (!lrst_s2_ff) begin
            crs_dv_ff <= 1'b0;
        end else if (rmii_lk) begin
            crs_dv_ff <= crs_s2_ff | take | (lst_ff == PMRX_ST_LO);
        end else begin
            crs_dv_ff <= crs_s2_ff;
        end
    end

    // Pin enables: released during reset so straps can be read.
    // RMII: bit 2 is open drain, driven only while the interrupt is active;
    // separate valid pin and bit 3 idle low.
    always_ff @(posedge rx_clk_i) begin
        if (!lrst_s2_ff) begin
            d_oe_ff  <= 4'h0;
            dv_oe_ff <= 1'b0;
        end else if (rmii_lk) begin
            d_oe_ff  <= {1'b1, ~irq_out_n, 2'h3};
            dv_oe_ff <= 1'b1;
        end else begin
            d_oe_ff  <= 4'hF;
            dv_oe_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////////

    // Every pin comes straight from a flop; ready is the FIFO's registered
    // not-full, and valid is already held low in RMII by its own flop
    assign sym_ready_o  = u_fifo_if.wr_ready;
    assign media_mode_o = mode_ff;
    assign ref_clk_o    = ref_clk_ff;
    assign ref_clk_oe_o = ref_oe_ff;
    assign rx_dv_o      = dv_ff;
    assign rx_dv_oe_o   = dv_oe_ff;
    assign rx_d_o       = d_ff;
    assign rx_d_oe_o    = d_oe_ff;
    assign rx_er_o      = er_ff;
    assign crs_dv_o     = crs_dv_ff;

endmodule // pmrx_rx_port

// ### test/pmrx_rx_checker.sv
// Checker for the receive port: watches only the top module's pins.
// Assumes media_mode_o is static outside reset and rx_clk_i runs always.
`timescale 1ns/1ps
module pmrx_rx_checker
    import pmrx_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       reset_n_i,
    input wire logic       rx_clk_i,
    input wire logic       irq_req_i,
    input wire logic       rx_dv_o,
    input wire logic       rx_dv_oe_o,
    input wire logic [3:0] rx_d_o,
    input wire logic [3:0] rx_d_oe_o,
    input wire logic       rx_er_o,
    input wire logic       crs_dv_o,
    input wire logic       ref_clk_o,
    input wire logic       ref_clk_oe_o,
    input wire pmrx_mode_t media_mode_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Mode, clock and interrupt pins on the system clock; MII pin enables on the link clock
    property p_mode_frozen;
        @(posedge clk_i) disable iff (!reset_n_i) $past(reset_n_i) |-> $stable(media_mode_o);
    endproperty
    a_mode_frozen: assert property (p_mode_frozen) else $error("mode moved");
    property p_ref_oe;
        @(posedge clk_i) disable iff (!reset_n_i) $past(reset_n_i) && $past(reset_n_i, 2)
            |-> ref_clk_oe_o == (media_mode_o == PMRX_RMII_CO);
    endproperty
    a_ref_oe: assert property (p_ref_oe) else $error("ref oe wrong");
    property p_ref_rate;
        @(posedge clk_i) disable iff (!reset_n_i) ref_clk_oe_o && $changed(ref_clk_o)
            |=> $stable(ref_clk_o) ##1 $changed(ref_clk_o);
    endproperty
    a_ref_rate: assert property (p_ref_rate) else $error("ref rate wrong");
    property p_irq_pin;
        @(posedge clk_i) disable iff (!reset_n_i) $rose(irq_req_i) && media_mode_o[1]
            |-> ##[1:20] (rx_d_oe_o[2] && !rx_d_o[2]);
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("irq not driven");
    property p_mii_oe;
        @(posedge rx_clk_i) disable iff (!reset_n_i) rx_dv_oe_o && !media_mode_o[1]
            |-> rx_d_oe_o == 4'hF;
    endproperty
    a_mii_oe: assert property (p_mii_oe) else $error("mii oe wrong");
    ////////////////////////////////////////////////////////////////////////////
    // Data pins on the link clock; interrupt cover on the system clock
    property p_mii_idle;
        @(posedge rx_clk_i) disable iff (!reset_n_i) !media_mode_o[1] && !rx_dv_o
            |-> rx_d_o == 4'h0 && !rx_er_o;
    endproperty
    a_mii_idle: assert property (p_mii_idle) else $error("idle data");
    property p_rmii_pins;
        @(posedge rx_clk_i) disable iff (!reset_n_i) media_mode_o[1]
            |-> !rx_dv_o && rx_d_o[3:2] == 2'h0;
    endproperty
    a_rmii_pins: assert property (p_rmii_pins) else $error("rmii pins");
    property p_rmii_crs;
        @(posedge rx_clk_i) disable iff (!reset_n_i) media_mode_o[1] && rx_d_o[1:0] != 2'h0
            |-> crs_dv_o;
    endproperty
    a_rmii_crs: assert property (p_rmii_crs) else $error("crs_dv low");
    c_err: cover property (@(posedge rx_clk_i) rx_er_o && rx_dv_o);
    c_rmii: cover property (@(posedge rx_clk_i) crs_dv_o && media_mode_o[1]);
    c_irq: cover property (@(posedge clk_i) rx_d_oe_o[2] && media_mode_o[1]);
endmodule // pmrx_rx_checker

bind pmrx_rx_port pmrx_rx_checker u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .rx_clk_i(rx_clk_i), .irq_req_i(irq_req_i), .rx_dv_o(rx_dv_o), .rx_dv_oe_o(rx_dv_oe_o),
    .rx_d_o(rx_d_o), .rx_d_oe_o(rx_d_oe_o), .rx_er_o(rx_er_o), .crs_dv_o(crs_dv_o),
    .ref_clk_o(ref_clk_o), .ref_clk_oe_o(ref_clk_oe_o), .media_mode_o(media_mode_o));

// ### test/pmrx_mac_model.sv
// MAC receive model: collects words {error, nibble} from the pin levels.
// Assumes released pins are already resolved to their pull-down level.
`timescale 1ns/1ps
module pmrx_mac_model (
    input wire logic       rx_clk_i,
    input wire logic       rmii_i,
    input wire logic       dv_pin_i,
    input wire logic       crs_pin_i,
    input wire logic [3:0] d_pin_i,
    input wire logic       er_pin_i
);
    logic [4:0] q[$];
    logic       ph;
    logic [1:0] lo;
    initial ph = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // Nibble per cycle in MII, low dibit then high dibit in RMII
    always @(posedge rx_clk_i) begin
        if (!rmii_i) begin
            if (dv_pin_i) q.push_back({er_pin_i, d_pin_i});
            ph <= 1'b0;
        end else if (crs_pin_i) begin
            ph <= !ph;
            if (!ph) lo <= d_pin_i[1:0];
            else q.push_back({er_pin_i, d_pin_i[1:0], lo});
        end else ph <= 1'b0;
    end
endmodule // pmrx_mac_model

// ### test/tb_phy_mii_rmii_receive_port.sv
// Testbench of the receive port: straps per mode, frames, FIFO fill, interrupt pin.
// Assumes the checker is bound by its own file and the MAC model sits on the pins.
`timescale 1ns/1ps
module tb_phy_mii_rmii_receive_port;
    import pmrx_pkg::*;
    logic       clk_i, reset_n_i, rx_clk_i, sym_valid_i, sym_err_i, sym_ready_o;
    logic       carrier_i, irq_req_i, strap_dv_i, strap_d3_i, rx_dv_o, rx_dv_oe_o;
    logic       rx_er_o, crs_dv_o, ref_clk_o, ref_clk_oe_o;
    logic [3:0] sym_data_i, rx_d_o, rx_d_oe_o, d_pin;
    logic       dv_pin, irq_n;
    pmrx_mode_t media_mode_o;
    int         num_errors, checked, stalls;
    logic [4:0] rw[4] = '{5'h0C, 5'h13, 5'h09, 5'h06};
    // Pull-downs on released pins, pull-up on the open-drain interrupt
    assign dv_pin = rx_dv_oe_o ? rx_dv_o : 1'b0;
    assign d_pin  = rx_d_o & rx_d_oe_o;
    assign irq_n  = rx_d_oe_o[2] ? rx_d_o[2] : 1'b1;
    pmrx_rx_port DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .rx_clk_i(rx_clk_i),
        .sym_valid_i(sym_valid_i), .sym_data_i(sym_data_i), .sym_err_i(sym_err_i),
        .sym_ready_o(sym_ready_o), .carrier_i(carrier_i), .irq_req_i(irq_req_i),
        .strap_dv_i(strap_dv_i), .strap_d3_i(strap_d3_i), .rx_dv_o(rx_dv_o),
        .rx_dv_oe_o(rx_dv_oe_o), .rx_d_o(rx_d_o), .rx_d_oe_o(rx_d_oe_o), .rx_er_o(rx_er_o),
        .crs_dv_o(crs_dv_o), .ref_clk_o(ref_clk_o), .ref_clk_oe_o(ref_clk_oe_o),
        .media_mode_o(media_mode_o));
    pmrx_mac_model mac (.rx_clk_i(rx_clk_i), .rmii_i(media_mode_o[1]), .dv_pin_i(dv_pin),
        .crs_pin_i(crs_dv_o), .d_pin_i(d_pin), .er_pin_i(rx_er_o));
    ////////////////////////////////////////////////////////////////////////////
    // Clocks; the link clock also stands in for the MAC's reference clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        rx_clk_i = 1'b0;
        #1.3;
        forever #6 rx_clk_i = ~rx_clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic do_reset(input logic [1:0] s);
        reset_n_i  <= 1'b0;
        strap_dv_i <= s[1];
        strap_d3_i <= s[0];
        repeat (12) @(posedge clk_i);
        mac.q.delete();
        reset_n_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        check(8'(media_mode_o), 8'(s));
        strap_dv_i <= ~s[1];
        strap_d3_i <= ~s[0];
        repeat (6) @(posedge clk_i);
        check(8'(media_mode_o), 8'(s));
    endtask
    task automatic send(input logic [4:0] w);
        int n;
        n = 0;
        sym_valid_i <= 1'b1;
        sym_data_i  <= w[3:0];
        sym_err_i   <= w[4];
        @(negedge clk_i);
        while (sym_ready_o !== 1'b1) begin
            stalls++;
            n++;
            if (n > 200) begin
                num_errors++;
                stop_test();
            end
            @(negedge clk_i);
        end
        @(posedge clk_i);
    endtask
    task automatic drain(input int k);
        int n;
        n = 0;
        while (mac.q.size() < k) begin
            n++;
            if (n > 3000) begin
                num_errors++;
                stop_test();
            end
            @(posedge clk_i);
        end
        repeat (20) @(posedge clk_i);
        check(8'(mac.q.size()), 8'(k));
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_mii();
        do_reset(2'h0);
        check(8'(rx_d_oe_o), 8'h0F);
        stalls = 0;
        for (int i = 0; i < 40; i++) send({i == 5, 4'(i)});
        sym_valid_i <= 1'b0;
        check(8'(stalls != 0), 8'h01);
        drain(40);
        for (int i = 0; i < 40; i++) check(8'(mac.q[i]), 8'({i == 5, 4'(i)}));
        irq_req_i <= 1'b1;
        repeat (30) @(posedge clk_i);
        check({rx_d_o, rx_d_oe_o}, 8'h0F);
        irq_req_i <= 1'b0;
        $display("test mii done");
    endtask
    task automatic t_rmii(input logic [1:0] s);
        do_reset(s);
        check(8'(ref_clk_oe_o), 8'(s == 2'h2));
        for (int i = 0; i < 4; i++) send(rw[i]);
        sym_valid_i <= 1'b0;
        drain(4);
        for (int i = 0; i < 4; i++) check(8'(mac.q[i]), 8'(rw[i]));
        irq_req_i <= 1'b1;
        repeat (30) @(posedge clk_i);
        check(8'(irq_n), 8'h00);
        irq_req_i <= 1'b0;
        repeat (30) @(posedge clk_i);
        check(8'(irq_n), 8'h01);
        carrier_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        check({7'h0, crs_dv_o}, 8'h01);
        carrier_i <= 1'b0;
        $display("test rmii done");
    endtask
    task automatic t_rev();
        do_reset(2'h1);
        check(8'(ref_clk_oe_o), 8'h00);
        for (int i = 0; i < 3; i++) send(rw[i]);
        sym_valid_i <= 1'b0;
        drain(3);
        for (int i = 0; i < 3; i++) check(8'(mac.q[i]), 8'(rw[i]));
        check(8'(rx_d_oe_o), 8'h0F);
        $display("test reverse mii done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset_n_i   = 1'b0;
        sym_valid_i = 1'b0;
        sym_data_i  = 4'h0;
        sym_err_i   = 1'b0;
        carrier_i   = 1'b0;
        irq_req_i   = 1'b0;
        strap_dv_i  = 1'b0;
        strap_d3_i  = 1'b0;
        num_errors  = 0;
        checked     = 0;
        t_mii();
        t_rmii(2'h2);
        t_rmii(2'h3);
        t_rev();
        stop_test();
    end
endmodule // tb_phy_mii_rmii_receive_port
